// >>> rtl/fsap_pkg.sv
package fsap_pkg;
	// address and status word widths
	localparam int ADDR_W = 24;
	localparam int SR_W   = 24;

	// serial command codes
	localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_READ_SR_LOW   = 8'h05;
	localparam logic [7:0] CMD_READ_SR_MID   = 8'h35;
	localparam logic [7:0] CMD_READ_SR_HIGH  = 8'h15;
	localparam logic [7:0] CMD_WRITE_SR_LOW  = 8'h01;
	localparam logic [7:0] CMD_WRITE_SR_MID  = 8'h31;
	localparam logic [7:0] CMD_WRITE_SR_HIGH = 8'h11;
	localparam logic [7:0] CMD_PAGE_PROGRAM  = 8'h02;
	localparam logic [7:0] CMD_QUAD_PROGRAM  = 8'h32;
	localparam logic [7:0] CMD_FAST_PROGRAM  = 8'hf2;
	localparam logic [7:0] CMD_SECTOR_ERASE  = 8'h20;
	localparam logic [7:0] CMD_BLK_ERASE_32  = 8'h52;
	localparam logic [7:0] CMD_BLK_ERASE_64  = 8'hd8;
	localparam logic [7:0] CMD_CHIP_ERASE    = 8'hc7;
	localparam logic [7:0] CMD_CHIP_ERASE_B  = 8'h60;
	localparam logic [7:0] CMD_SUSPEND       = 8'h75;
	localparam logic [7:0] CMD_RESUME        = 8'h7a;
	localparam logic [7:0] CMD_RESET_ENABLE  = 8'h66;
	localparam logic [7:0] CMD_RESET         = 8'h99;

	// bit positions within the 24-bit status word
	localparam int BUSY_POS    = 0;
	localparam int WEL_POS     = 1;
	localparam int BP_LSB      = 2;
	localparam int SRP_LO_POS  = 7;
	localparam int SRP_HI_POS  = 8;
	localparam int QE_POS      = 9;
	localparam int SUS_PRG_POS = 10;
	localparam int LOCK_LSB    = 11;
	localparam int CMP_POS     = 14;
	localparam int SUS_ERS_POS = 15;
	localparam int HPF_POS     = 20;
	localparam int DRV_LSB     = 21;

	// reset values of the control fields
	localparam logic [4:0] BP_RST   = 5'h00;
	localparam logic [1:0] SRP_RST  = 2'h0;
	localparam logic       QE_RST   = 1'b0;
	localparam logic [2:0] LOCK_RST = 3'h0;
	localparam logic       CMP_RST  = 1'b0;
	localparam logic [1:0] DRV_RST  = 2'h1;

	// status-protect modes as {hi, lo}
	localparam logic [1:0] SRP_SOFT     = 2'b00;
	localparam logic [1:0] SRP_HARDWARE = 2'b01;

	// default status-write busy time in mclk cycles
	localparam int SRW_CYCLES = 16;

	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_PROGRAM   = 3'h1,
		OP_SECTOR    = 3'h2,
		OP_BLOCK_32  = 3'h3,
		OP_BLOCK_64  = 3'h4,
		OP_CHIP      = 3'h5,
		OP_SUSPEND   = 3'h6,
		OP_RESUME    = 3'h7
	} fsap_op_e;

	typedef struct packed {
		logic                valid;
		fsap_op_e            kind;
		logic [ADDR_W-1:0]   addr;
	} fsap_op_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_READ  = 3'b100
	} fsap_state_e;
endpackage

// >>> rtl/fsap_top.sv
`timescale 1ns/100ps
// Functional notes
// - busy flag bit 0 is high during program, erase or status write
// - write-enable latch in bit 1; when low refuse status write, program, erase
// - block-protect bits 6..2 select region refusing program and erases
// - block-protect bits change only when hardware protection not in force
// - chip erase only when low three protect bits match complement bit
// - protect mode 00: status writable whenever write-enable latch set and busy flag clear
// - protect mode 01: pin low locks status, pin high allows writes
// - protect mode 10: status locked until power cycle, which returns 00
// - protect mode 11: status refuses writes until power cycle, which returns 00
// - quad enable bit 9 defaults 0; drives quad_enable only, protect pin still gates writes
// - lock bits 13..11 default 0, set individually, clear only at power cycle
// - complement bit 14 defaults 0 and joins protect bits for region
// - complement set inverts the protection map
// - suspend sets erase flag bit 15 or program flag bit 10
// - resume, software reset pair or power cycle clear suspend flags
// - read-only flag bit 20 shows high-performance mode, default 0
// - drive field bits 22..21: 00 full, 01 default, 10 half, 11 quarter
// - complement clear: fractions or 4KB..32KB top/bottom when bit 6 set
// - write enable sets latch when not busy; disable, status write, program, erase, reset clear
// - hardware protection with pin low guards protect and mode bits
module fsap_top #(
	parameter int SRW_CNT = fsap_pkg::SRW_CYCLES
) (
	// clock and reset
	input  logic              mclk,
	input  logic              rst_n,
	// serial bus pins
	input  logic              spi_sclk,
	input  logic              spi_cs_n,
	input  logic              spi_si,
	input  logic              wp_n,
	output logic              spi_so,
	output logic              spi_so_oe_n,
	// array engine side
	input  logic              array_busy,
	input  logic              array_erasing,
	input  logic              high_perf_mode,
	output fsap_pkg::fsap_op_s op_req,
	// configuration outputs
	output logic              busy_flag,
	output logic              quad_enable,
	output logic [2:0]        security_lock,
	output logic [1:0]        drive_strength
);
	// protected-address decode for one protect setting
	function automatic logic prot_hit(input logic [4:0] bp, input logic cmp,
		input logic [fsap_pkg::ADDR_W-1:0] a);
		logic [2:0]  lo;
		logic [4:0]  e;
		logic [22:0] m;
		logic        hit;
		lo  = bp[2:0];
		hit = 1'b0;
		e   = 5'd0;
		m   = 23'h0;
		if (lo == 3'b111) begin
			hit = 1'b1;
		end else if (lo != 3'b000) begin
			if (!bp[4]) begin
				e = 5'd16 + {2'b00, lo};
			end else if (lo[2]) begin
				e = 5'd15;
			end else begin
				e = 5'd11 + {2'b00, lo};
			end
			m = 23'((24'h1 << e) - 24'h1);
			if (!bp[3]) begin
				hit = ((a[22:0] | m) == 23'h7fffff);
			end else begin
				hit = ((a[22:0] & ~m) == 23'h0);
			end
		end
		return hit ^ cmp;
	endfunction

	// pin synchronisers
	logic sclk_s1, sclk_s2, sclk_d, cs_s1, cs_s2, cs_d, si_s1, si_s2, wp_s1, wp_s2;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{sclk_s1, sclk_s2, sclk_d} <= 3'h0;
			{cs_s1, cs_s2, cs_d}       <= 3'h7;
			{si_s1, si_s2, wp_s1, wp_s2} <= 4'h0;
		end else begin
			sclk_s1 <= spi_sclk;
			sclk_s2 <= sclk_s1;
			sclk_d  <= sclk_s2;
			cs_s1   <= spi_cs_n;
			cs_s2   <= cs_s1;
			cs_d    <= cs_s2;
			si_s1   <= spi_si;
			si_s2   <= si_s1;
			wp_s1   <= wp_n;
			wp_s2   <= wp_s1;
		end
	end

	// edge events in the mclk domain
	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	assign sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
	assign sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
	assign cs_fall   = ~cs_s2 & cs_d;
	assign cs_rise   = cs_s2 & ~cs_d;

	// frame state
	fsap_pkg::fsap_state_e state_r, state_nxt;
	logic [2:0]  bit_r, bit_nxt, bytes_r, bytes_nxt, rd_bit_r, rd_bit_nxt;
	logic [7:0]  shift_r, shift_nxt, cmd_r, cmd_nxt, data_r, data_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic [1:0]  rd_sel_r, rd_sel_nxt;
	logic        so_r, so_nxt, so_oe_n_r, so_oe_n_nxt;
	logic [23:0] stat;
	logic [7:0]  rd_byte;

	// read byte select
	always_comb begin
		unique case (rd_sel_r)
			2'd1:    rd_byte = stat[15:8];
			2'd2:    rd_byte = stat[23:16];
			default: rd_byte = stat[7:0];
		endcase
	end

	// frame shifter and status read-out
	always_comb begin
		logic [7:0] sh;
		sh          = {shift_r[6:0], si_s2};
		state_nxt   = state_r;
		bit_nxt     = bit_r;
		bytes_nxt   = bytes_r;
		shift_nxt   = shift_r;
		cmd_nxt     = cmd_r;
		data_nxt    = data_r;
		addr_nxt    = addr_r;
		rd_sel_nxt  = rd_sel_r;
		rd_bit_nxt  = rd_bit_r;
		so_nxt      = so_r;
		so_oe_n_nxt = so_oe_n_r;
		if (cs_rise) begin
			state_nxt   = fsap_pkg::ST_IDLE;
			so_oe_n_nxt = 1'b1;
		end else if (cs_fall) begin
			state_nxt = fsap_pkg::ST_SHIFT;
			bit_nxt   = 3'd0;
			bytes_nxt = 3'd0;
		end else if (sclk_rise && state_r == fsap_pkg::ST_SHIFT) begin
			shift_nxt = sh;
			bit_nxt   = bit_r + 3'd1;
			if (bit_r == 3'd7) begin
				if (bytes_r != 3'd7) begin
					bytes_nxt = bytes_r + 3'd1;
				end
				if (bytes_r == 3'd0) begin
					cmd_nxt = sh;
					rd_bit_nxt = 3'd0;
					if (sh == fsap_pkg::CMD_READ_SR_LOW || sh == fsap_pkg::CMD_READ_SR_MID ||
						sh == fsap_pkg::CMD_READ_SR_HIGH) begin
						state_nxt  = fsap_pkg::ST_READ;
						rd_sel_nxt = (sh == fsap_pkg::CMD_READ_SR_MID) ? 2'd1 :
							(sh == fsap_pkg::CMD_READ_SR_HIGH) ? 2'd2 : 2'd0;
					end
				end else if (bytes_r <= 3'd3) begin
					addr_nxt = {addr_r[15:0], sh};
				end
				if (bytes_r == 3'd1) begin
					data_nxt = sh;
				end
			end
		end else if (sclk_fall && state_r == fsap_pkg::ST_READ) begin
			// continuous read of a live status byte, msb first
			so_nxt      = rd_byte[3'd7 - rd_bit_r];
			so_oe_n_nxt = 1'b0;
			rd_bit_nxt  = rd_bit_r + 3'd1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r   <= fsap_pkg::ST_IDLE;
			bit_r     <= 3'd0;
			bytes_r   <= 3'd0;
			shift_r   <= 8'h00;
			cmd_r     <= 8'h00;
			data_r    <= 8'h00;
			addr_r    <= 24'h000000;
			rd_sel_r  <= 2'd0;
			rd_bit_r  <= 3'd0;
			so_r      <= 1'b0;
			so_oe_n_r <= 1'b1;
		end else begin
			state_r   <= state_nxt;
			bit_r     <= bit_nxt;
			bytes_r   <= bytes_nxt;
			shift_r   <= shift_nxt;
			cmd_r     <= cmd_nxt;
			data_r    <= data_nxt;
			addr_r    <= addr_nxt;
			rd_sel_r  <= rd_sel_nxt;
			rd_bit_r  <= rd_bit_nxt;
			so_r      <= so_nxt;
			so_oe_n_r <= so_oe_n_nxt;
		end
	end

	// status and control state
	logic [4:0]  bp_r, bp_nxt;
	logic [1:0]  srp_r, srp_nxt, drv_r, drv_nxt;
	logic [2:0]  lock_r, lock_nxt;
	logic        wel_r, wel_nxt, qe_r, qe_nxt, cmp_r, cmp_nxt;
	logic        sus_e_r, sus_e_nxt, sus_p_r, sus_p_nxt, hpf_r, hpf_nxt;
	logic        busy_r, busy_nxt, armed_r, armed_nxt;
	logic [15:0] srw_r, srw_nxt;
	fsap_pkg::fsap_op_s op_r, op_nxt;
	logic        exec, sr_cmd, sr_ok, sr_wr, pe_cmd, chip_ok, addr_prot, pe_go;

	// live status word, reserved bits zero
	always_comb begin
		stat = 24'h000000;
		stat[fsap_pkg::BUSY_POS]                = busy_r;
		stat[fsap_pkg::WEL_POS]                 = wel_r;
		stat[fsap_pkg::BP_LSB +: 5]             = bp_r;
		stat[fsap_pkg::SRP_LO_POS]              = srp_r[0];
		stat[fsap_pkg::SRP_HI_POS]              = srp_r[1];
		stat[fsap_pkg::QE_POS]                  = qe_r;
		stat[fsap_pkg::SUS_PRG_POS]             = sus_p_r;
		stat[fsap_pkg::LOCK_LSB +: 3]           = lock_r;
		stat[fsap_pkg::CMP_POS]                 = cmp_r;
		stat[fsap_pkg::SUS_ERS_POS]             = sus_e_r;
		stat[fsap_pkg::HPF_POS]                 = hpf_r;
		stat[fsap_pkg::DRV_LSB +: 2]            = drv_r;
	end

	// command gating at deselect on a byte boundary
	assign exec   = cs_rise & (state_r == fsap_pkg::ST_SHIFT) & (bit_r == 3'd0) &
		(bytes_r != 3'd0);
	assign sr_cmd = (cmd_r == fsap_pkg::CMD_WRITE_SR_LOW) | (cmd_r == fsap_pkg::CMD_WRITE_SR_MID) |
		(cmd_r == fsap_pkg::CMD_WRITE_SR_HIGH);
	// status write permission by protect mode
	assign sr_ok  = wel_r & ~busy_r & ((srp_r == fsap_pkg::SRP_SOFT) |
		((srp_r == fsap_pkg::SRP_HARDWARE) & wp_s2));
	assign sr_wr  = exec & sr_cmd & (bytes_r >= 3'd2) & sr_ok;
	assign chip_ok   = ((bp_r[2:0] == 3'b000) & ~cmp_r) | ((bp_r[2:0] == 3'b111) & cmp_r);
	assign addr_prot = prot_hit(bp_r, cmp_r, addr_r);

	always_comb begin
		logic [2:0] kind;
		logic       ce;
		kind = 3'd0;
		ce   = (cmd_r == fsap_pkg::CMD_CHIP_ERASE) | (cmd_r == fsap_pkg::CMD_CHIP_ERASE_B);
		unique case (cmd_r)
			fsap_pkg::CMD_PAGE_PROGRAM, fsap_pkg::CMD_QUAD_PROGRAM,
			fsap_pkg::CMD_FAST_PROGRAM: kind = (bytes_r >= 3'd5) ? 3'd1 : 3'd0;
			fsap_pkg::CMD_SECTOR_ERASE: kind = (bytes_r >= 3'd4) ? 3'd2 : 3'd0;
			fsap_pkg::CMD_BLK_ERASE_32: kind = (bytes_r >= 3'd4) ? 3'd3 : 3'd0;
			fsap_pkg::CMD_BLK_ERASE_64: kind = (bytes_r >= 3'd4) ? 3'd4 : 3'd0;
			fsap_pkg::CMD_CHIP_ERASE, fsap_pkg::CMD_CHIP_ERASE_B: kind = 3'd5;
			default: kind = 3'd0;
		endcase
		pe_cmd = exec & (kind != 3'd0);
		pe_go  = pe_cmd & wel_r & ~busy_r & (ce ? chip_ok : ~addr_prot);
		bp_nxt    = bp_r;
		srp_nxt   = srp_r;
		drv_nxt   = drv_r;
		lock_nxt  = lock_r;
		qe_nxt    = qe_r;
		cmp_nxt   = cmp_r;
		wel_nxt   = wel_r;
		sus_e_nxt = sus_e_r;
		sus_p_nxt = sus_p_r;
		armed_nxt = armed_r;
		op_nxt    = '0;
		srw_nxt   = (srw_r != 16'h0) ? srw_r - 16'h1 : 16'h0;
		hpf_nxt   = high_perf_mode;
		if (exec) begin
			armed_nxt = (cmd_r == fsap_pkg::CMD_RESET_ENABLE);
		end
		// write enable latch set and clear
		if (exec && cmd_r == fsap_pkg::CMD_WRITE_ENABLE && !busy_r) begin
			wel_nxt = 1'b1;
		end
		if (exec && cmd_r == fsap_pkg::CMD_WRITE_DISABLE) begin
			wel_nxt = 1'b0;
		end
		if (pe_cmd || (exec && sr_cmd && sr_ok)) begin
			wel_nxt = 1'b0;
		end
		if (sr_wr) begin
			srw_nxt = 16'(SRW_CNT);
			if (cmd_r == fsap_pkg::CMD_WRITE_SR_LOW) begin
				bp_nxt     = data_r[fsap_pkg::BP_LSB +: 5];
				srp_nxt[0] = data_r[fsap_pkg::SRP_LO_POS];
			end else if (cmd_r == fsap_pkg::CMD_WRITE_SR_MID) begin
				srp_nxt[1] = data_r[fsap_pkg::SRP_HI_POS - 8];
				qe_nxt     = data_r[fsap_pkg::QE_POS - 8];
				cmp_nxt    = data_r[fsap_pkg::CMP_POS - 8];
				lock_nxt   = lock_r | data_r[fsap_pkg::LOCK_LSB - 8 +: 3];
			end else begin
				drv_nxt    = data_r[fsap_pkg::DRV_LSB - 16 +: 2];
			end
		end
		if (pe_go) begin
			op_nxt.valid = 1'b1;
			op_nxt.kind  = fsap_pkg::fsap_op_e'(kind);
			op_nxt.addr  = addr_r;
		end
		if (exec && cmd_r == fsap_pkg::CMD_SUSPEND && array_busy) begin
			sus_e_nxt    = sus_e_r | array_erasing;
			sus_p_nxt    = sus_p_r | ~array_erasing;
			op_nxt.valid = 1'b1;
			op_nxt.kind  = fsap_pkg::OP_SUSPEND;
		end
		// resume or reset pair clears suspend
		if (exec && cmd_r == fsap_pkg::CMD_RESUME) begin
			sus_e_nxt    = 1'b0;
			sus_p_nxt    = 1'b0;
			op_nxt.valid = 1'b1;
			op_nxt.kind  = fsap_pkg::OP_RESUME;
		end
		if (exec && cmd_r == fsap_pkg::CMD_RESET && armed_r) begin
			sus_e_nxt = 1'b0;
			sus_p_nxt = 1'b0;
			wel_nxt   = 1'b0;
		end
		// busy from engine, status write timer or new launch
		busy_nxt = array_busy | (srw_nxt != 16'h0) | pe_go;
	end

	// reset plays the power cycle, mode bits back to 00
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bp_r    <= fsap_pkg::BP_RST;
			srp_r   <= fsap_pkg::SRP_RST;
			drv_r   <= fsap_pkg::DRV_RST;
			lock_r  <= fsap_pkg::LOCK_RST;
			qe_r    <= fsap_pkg::QE_RST;
			cmp_r   <= fsap_pkg::CMP_RST;
			wel_r   <= 1'b0;
			sus_e_r <= 1'b0;
			sus_p_r <= 1'b0;
			hpf_r   <= 1'b0;
			busy_r  <= 1'b0;
			armed_r <= 1'b0;
			srw_r   <= 16'h0;
			op_r    <= '0;
		end else begin
			bp_r    <= bp_nxt;
			srp_r   <= srp_nxt;
			drv_r   <= drv_nxt;
			lock_r  <= lock_nxt;
			qe_r    <= qe_nxt;
			cmp_r   <= cmp_nxt;
			wel_r   <= wel_nxt;
			sus_e_r <= sus_e_nxt;
			sus_p_r <= sus_p_nxt;
			hpf_r   <= hpf_nxt;
			busy_r  <= busy_nxt;
			armed_r <= armed_nxt;
			srw_r   <= srw_nxt;
			op_r    <= op_nxt;
		end
	end

	// outputs straight from flops
	assign spi_so         = so_r;
	assign spi_so_oe_n    = so_oe_n_r;
	assign op_req         = op_r;
	assign busy_flag      = busy_r;
	assign quad_enable    = qe_r;
	assign security_lock  = lock_r;
	assign drive_strength = drv_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_busy_follow: assert property (array_busy |=> busy_r) else $error("busy not shown");
	a_wel_gate: assert property (op_r.valid && op_r.kind inside {fsap_pkg::OP_PROGRAM,
		fsap_pkg::OP_SECTOR, fsap_pkg::OP_BLOCK_32, fsap_pkg::OP_BLOCK_64,
		fsap_pkg::OP_CHIP} |-> $past(wel_r) && !$past(busy_r))
		else $error("launch without write enable");
	a_prot_gate: assert property (op_r.valid && op_r.kind inside {fsap_pkg::OP_PROGRAM,
		fsap_pkg::OP_SECTOR, fsap_pkg::OP_BLOCK_32, fsap_pkg::OP_BLOCK_64} |-> !$past(addr_prot))
		else $error("protected address launched");
	a_chip_gate: assert property (op_r.valid && op_r.kind == fsap_pkg::OP_CHIP |->
		$past(chip_ok)) else $error("chip erase not allowed");
	a_hw_lock: assert property (srp_r == fsap_pkg::SRP_HARDWARE && !wp_s2 |=>
		$stable(bp_r) && $stable(srp_r)) else $error("hardware lock broken");
	a_lockdown: assert property (srp_r[1] |=> $stable(stat[15:2]) || $changed(sus_e_r) ||
		$changed(sus_p_r)) else $error("locked status changed");
	a_lock_sticky: assert property (($past(lock_r) & ~lock_r) == 3'h0)
		else $error("lock bit cleared");
	a_resume_clr: assert property (exec && cmd_r == fsap_pkg::CMD_RESUME |=>
		!sus_e_r && !sus_p_r) else $error("suspend not cleared");
	a_wel_clear: assert property (sr_wr |=> !wel_r && busy_r) else $error("latch not cleared");
	a_reserved: assert property (stat[23] == 1'b0 && stat[19:16] == 4'h0 ##1
		stat[19:16] == 4'h0) else $error("reserved bit set");
endmodule

// >>> testbench/fsap_host.sv
`timescale 1ns/100ps
// serial bus host, mode 0, msb first, sclk half period of 8 mclk
module fsap_host (
	// system clock
	input  wire logic mclk,
	// serial bus pins
	output logic      spi_sclk,
	output logic      spi_cs_n,
	output logic      spi_si,
	input  wire logic spi_so
);
	// idle bus, clock stands low between frames
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_si   = 1'b0;
	end

	// wait falling mclk edges
	task automatic gap(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// one frame, tx left aligned, last eight bits seen on so returned
	task automatic xfer(input logic [39:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		gap(1);
		spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_si = tx[39-i];
			gap(8);
			spi_sclk = 1'b1;
			rx = {rx[6:0], spi_so};
			gap(8);
			spi_sclk = 1'b0;
		end
		gap(8);
		spi_cs_n = 1'b1;
		// released line shows the inverse of its last value
		spi_si = ~spi_si;
		gap(8);
	endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	// design side signals
	logic               mclk;
	logic               rst_n;
	logic               wp_n;
	logic               array_erasing;
	logic               high_perf_mode;
	logic               spi_so;
	logic               spi_so_oe_n;
	logic               busy_flag;
	logic               quad_enable;
	logic [2:0]         security_lock;
	logic [1:0]         drive_strength;
	wire                spi_sclk;
	wire                spi_cs_n;
	wire                spi_si;
	wire                array_busy;
	wire                so_line;
	fsap_pkg::fsap_op_s op_req;
	// bench state
	fsap_pkg::fsap_op_s last_op;
	logic               op_seen;
	logic [7:0]         rd;
	int                 err_total;
	int                 n_checks;
	int                 cyc;
	int                 acnt;

	fsap_top dut (
		.mclk(mclk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_si(spi_si), .wp_n(wp_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
		.array_busy(array_busy), .array_erasing(array_erasing),
		.high_perf_mode(high_perf_mode), .op_req(op_req), .busy_flag(busy_flag),
		.quad_enable(quad_enable), .security_lock(security_lock),
		.drive_strength(drive_strength)
	);

	fsap_host host (
		.mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
		.spi_so(so_line)
	);

	// clock
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// array engine: busy 300 cycles per operation, suspend stops, resume runs 50 cycles
	assign array_busy = (acnt != 0);
	// released data line shows the inverse of its last value
	assign so_line = spi_so_oe_n ? ~spi_so : spi_so;
	always @(negedge mclk) begin
		cyc <= cyc + 1;
		if (acnt > 0) acnt <= acnt - 1;
		if (op_req.valid === 1'b1) begin
			op_seen <= 1'b1;
			last_op <= op_req;
			if (op_req.kind == fsap_pkg::OP_SUSPEND) acnt <= 0;
			else if (op_req.kind == fsap_pkg::OP_RESUME) acnt <= 50;
			else begin
				acnt          <= 300;
				array_erasing <= (op_req.kind != fsap_pkg::OP_PROGRAM);
			end
		end
		if (cyc == 60000) begin
			err_total++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask

	// read one status byte
	task automatic rsr(input logic [7:0] cmd, input logic [7:0] exp, input string nm);
		host.xfer({cmd, 32'h0}, 16, rd);
		chk(nm, 24'(exp), 24'(rd));
		chk("so released", 24'h1, 24'(spi_so_oe_n));
	endtask

	// bounded wait for the busy flag to drop
	task automatic idle();
		host.gap(4);
		for (int i = 0; i < 3000 && busy_flag !== 1'b0; i++) host.gap(1);
	endtask

	task automatic wen();
		host.xfer({fsap_pkg::CMD_WRITE_ENABLE, 32'h0}, 8, rd);
	endtask

	// status write after write enable; busy shows only if it was taken
	task automatic wsr(input logic [7:0] cmd, input logic [7:0] val, input logic ok);
		wen();
		host.xfer({cmd, val, 24'h0}, 16, rd);
		chk("sr write busy", 24'(ok), 24'(busy_flag));
		idle();
		if (!ok) host.xfer({fsap_pkg::CMD_WRITE_DISABLE, 32'h0}, 8, rd);
	endtask

	// array command after write enable, checks issue, kind, address, busy
	task automatic op(input logic [7:0] cmd, input logic [23:0] a, input int nb,
			input logic ok, input fsap_pkg::fsap_op_e k);
		wen();
		op_seen = 1'b0;
		host.xfer({cmd, a, 8'h5a}, nb, rd);
		host.gap(2);
		chk("op issued", 24'(ok), 24'(op_seen));
		if (ok) begin
			chk("op kind", 24'(k), 24'(last_op.kind));
			if (nb > 8) chk("op addr", a, last_op.addr);
			chk("op busy", 24'h1, 24'(busy_flag));
			idle();
		end
	endtask

	task automatic pwr();
		rst_n = 1'b0;
		host.gap(8);
		rst_n = 1'b1;
		host.gap(4);
	endtask

	initial begin
		err_total      = 0;
		n_checks       = 0;
		cyc            = 0;
		acnt           = 0;
		op_seen        = 1'b0;
		last_op        = '0;
		wp_n           = 1'b0;
		array_erasing  = 1'b0;
		high_perf_mode = 1'b0;
		pwr();
		// reset values
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "sr low");
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h00, "sr mid");
		rsr(fsap_pkg::CMD_READ_SR_HIGH, 8'h20, "sr high");
		chk("drive", 24'h1, 24'(drive_strength));
		chk("quad", 24'h0, 24'(quad_enable));
		chk("locks", 24'h0, 24'(security_lock));
		tend("reset");
		// latch set and clear, off-boundary and unlatched refusals
		host.xfer({fsap_pkg::CMD_WRITE_ENABLE, 32'h0}, 12, rd);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "short frame");
		wen();
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h02, "latch set");
		host.xfer({fsap_pkg::CMD_WRITE_DISABLE, 32'h0}, 8, rd);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "latch clear");
		op_seen = 1'b0;
		host.xfer({fsap_pkg::CMD_WRITE_SR_LOW, 8'h1c, 24'h0}, 16, rd);
		host.xfer({fsap_pkg::CMD_PAGE_PROGRAM, 32'h0001005a}, 40, rd);
		chk("unlatched op", 24'h0, 24'(op_seen));
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "unlatched sr");
		tend("latch");
		// chip erase and protection maps
		op(fsap_pkg::CMD_CHIP_ERASE, 24'h0, 8, 1'b1, fsap_pkg::OP_CHIP);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "latch after erase");
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h1c, 1'b1);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h1c, "bp all");
		op(fsap_pkg::CMD_PAGE_PROGRAM, 24'h000100, 40, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_CHIP_ERASE_B, 24'h0, 8, 1'b0, fsap_pkg::OP_NONE);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h04, 1'b1);
		op(fsap_pkg::CMD_PAGE_PROGRAM, 24'h7e0000, 40, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_PAGE_PROGRAM, 24'h7dffff, 40, 1'b1, fsap_pkg::OP_PROGRAM);
		op(fsap_pkg::CMD_BLK_ERASE_32, 24'h7f0000, 32, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_BLK_ERASE_64, 24'h000000, 32, 1'b1, fsap_pkg::OP_BLOCK_64);
		op(fsap_pkg::CMD_QUAD_PROGRAM, 24'h400000, 40, 1'b1, fsap_pkg::OP_PROGRAM);
		op(fsap_pkg::CMD_FAST_PROGRAM, 24'h7fffff, 40, 1'b0, fsap_pkg::OP_NONE);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h64, 1'b1);
		op(fsap_pkg::CMD_SECTOR_ERASE, 24'h000000, 32, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_SECTOR_ERASE, 24'h001000, 32, 1'b1, fsap_pkg::OP_SECTOR);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h04, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h40, 1'b1);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h40, "cmp set");
		op(fsap_pkg::CMD_PAGE_PROGRAM, 24'h7e0000, 40, 1'b1, fsap_pkg::OP_PROGRAM);
		op(fsap_pkg::CMD_SECTOR_ERASE, 24'h7df000, 32, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_BLK_ERASE_32, 24'h7f8000, 32, 1'b1, fsap_pkg::OP_BLOCK_32);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h1c, 1'b1);
		op(fsap_pkg::CMD_CHIP_ERASE, 24'h0, 8, 1'b1, fsap_pkg::OP_CHIP);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h00, 1'b1);
		op(fsap_pkg::CMD_PAGE_PROGRAM, 24'h7ff000, 40, 1'b0, fsap_pkg::OP_NONE);
		op(fsap_pkg::CMD_CHIP_ERASE, 24'h0, 8, 1'b0, fsap_pkg::OP_NONE);
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h00, 1'b1);
		tend("protect");
		// suspend flags, resume and software reset
		wen();
		host.xfer({fsap_pkg::CMD_SECTOR_ERASE, 32'h00100000}, 32, rd);
		host.xfer({fsap_pkg::CMD_SUSPEND, 32'h0}, 8, rd);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h80, "erase suspend");
		host.xfer({fsap_pkg::CMD_RESUME, 32'h0}, 8, rd);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h00, "resume");
		idle();
		wen();
		host.xfer({fsap_pkg::CMD_PAGE_PROGRAM, 32'h0020005a}, 40, rd);
		host.xfer({fsap_pkg::CMD_SUSPEND, 32'h0}, 8, rd);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h04, "program suspend");
		wen();
		host.xfer({fsap_pkg::CMD_RESET_ENABLE, 32'h0}, 8, rd);
		host.xfer({fsap_pkg::CMD_RESET, 32'h0}, 8, rd);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h00, "soft reset");
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h00, "soft reset latch");
		tend("suspend");
		// quad enable and one-time locks
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h0a, 1'b1);
		chk("quad on", 24'h1, 24'(quad_enable));
		chk("lock one", 24'h1, 24'(security_lock));
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h30, 1'b1);
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h38, "locks kept");
		chk("quad off", 24'h0, 24'(quad_enable));
		tend("config");
		// every drive code, reserved bits ignored, performance flag
		high_perf_mode = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wsr(fsap_pkg::CMD_WRITE_SR_HIGH, {1'b1, 2'(i), 5'h1f}, 1'b1);
			rsr(fsap_pkg::CMD_READ_SR_HIGH, {1'b0, 2'(i), 5'h10}, "sr high");
			chk("drive", 24'(i), 24'(drive_strength));
		end
		high_perf_mode = 1'b0;
		rsr(fsap_pkg::CMD_READ_SR_HIGH, 8'h60, "perf off");
		tend("drive");
		// status protect modes
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h80, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h1c, 1'b0);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h80, "pin locked");
		wp_n = 1'b1;
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h1c, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h01, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h00, 1'b0);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h1c, "lock-down");
		pwr();
		rsr(fsap_pkg::CMD_READ_SR_MID, 8'h00, "power cycle");
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h80, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_MID, 8'h01, 1'b1);
		wsr(fsap_pkg::CMD_WRITE_SR_LOW, 8'h04, 1'b0);
		rsr(fsap_pkg::CMD_READ_SR_LOW, 8'h80, "one time");
		tend("modes");
		conclude();
	end
endmodule
